//--- verilog/sfs_pkg.sv
/*
  Constants, opcodes, status layout and phase type for the serial flash
  security-register and status command block.
  Assumes a single 50 MHz system clock; no other dependencies.
*/
`default_nettype none

package sfs_pkg;

  // ==========================================================
  // clocking and timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  // default self-timed program duration in microseconds (plain default)
  localparam int SEC_PROG_TIME_US = 500;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_SECURITY = 8'h77;
  localparam logic [7:0] OP_PROG_SECURITY = 8'h9B;

  // ==========================================================
  // security register geometry
  localparam int SEC_BYTES = 128;
  localparam int USER_BYTES = 64;
  localparam int BUF_BYTES = 256;
  localparam int ADDR_BYTES = 3;
  localparam int DUMMY_BYTES = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // device_status bit positions
  localparam int ST_READY_BUSY = 0;
  localparam int ST_WRITE_ENABLE = 1;
  localparam int ST_ARRAY_PROTECT = 2;
  localparam int ST_RESERVED_LO = 3;
  localparam int ST_PROTECT_PIN = 4;
  localparam int ST_PROG_ERROR = 5;
  localparam int ST_RESERVED_HI = 6;
  localparam int ST_PROTECT_LOCK = 7;

  // ==========================================================
  // reset values of the writable/latched status bits
  localparam logic RST_WRITE_ENABLE = 1'b0;
  localparam logic RST_ARRAY_PROTECT = 1'b0;
  localparam logic RST_PROTECT_LOCK = 1'b0;
  localparam logic RST_PROG_ERROR = 1'b0;

  // ==========================================================
  // command phases
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_READ_SEC,
    PH_READ_STATUS,
    PH_PROG_DATA,
    PH_STATUS_DATA,
    PH_TAIL
  } sfs_phase_e;

endpackage

`default_nettype wire

//--- verilog/sfs_pins_if.sv
/*
  Carrier for the synchronised SPI pin events between the pin sampler
  and the command engine. Assumes both sit on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface sfs_pins_if;
  logic csActive;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic si;
  logic wpAsserted;

  modport src (
    output csActive,
    output csRise,
    output sckRise,
    output sckFall,
    output si,
    output wpAsserted
  );

  modport dst (
    input csActive,
    input csRise,
    input sckRise,
    input sckFall,
    input si,
    input wpAsserted
  );
endinterface

`default_nettype wire

//--- verilog/sfs_pin_sync.sv
/*
  Two-flop synchronisers for the SPI pins and the write-protect pin, plus
  edge detection of chip select and serial clock.
  Assumes the serial clock is at most about a sixth of clk.
*/
`timescale 1ns/100ps
`default_nettype none

module sfs_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiSi,
  input wire logic wpN,
  // synchronised events
  sfs_pins_if.src pins
);

  typedef struct packed {
    logic [2:0] cs;
    logic [2:0] sck;
    logic [1:0] si;
    logic [1:0] wp;
  } sfs_sync_s;

  sfs_sync_s s_q;
  sfs_sync_s s_d;

  // ==========================================================
  // sampling chain
  always_comb begin
    s_d = s_q;
    s_d.cs = {s_q.cs[1:0], spiCsN};
    s_d.sck = {s_q.sck[1:0], spiClk};
    s_d.si = {s_q.si[0], spiSi};
    s_d.wp = {s_q.wp[0], wpN};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{cs: 3'h7, sck: 3'h0, si: 2'h0, wp: 2'h3};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // events: only stages 1 and 2 are read, stage 0 feeds stage 1 alone
  assign pins.csActive = ~s_q.cs[1];
  assign pins.csRise = s_q.cs[1] & ~s_q.cs[2];
  // clock edges only count inside a frame
  assign pins.sckRise = ~s_q.cs[1] & s_q.sck[1] & ~s_q.sck[2];
  assign pins.sckFall = ~s_q.cs[1] & ~s_q.sck[1] & s_q.sck[2];
  assign pins.si = s_q.si[1];
  assign pins.wpAsserted = ~s_q.wp[1];

endmodule // sfs_pin_sync

`default_nettype wire

//--- verilog/sfs_flash_top.sv
/*
  Command engine of a serial flash: 128-byte security register (read), lower
  64 bytes one-time-programmable, status register read/write, write enable
  and disable. Holds the shared 256-byte program buffer.
  Assumes an SPI host in mode 0 or 3 with the serial clock slow enough
  (well under clk/6) for pin sampling; the far side resolves the tristate
  data output from spiSoOe.
*/
`timescale 1ns/100ps
`default_nettype none

module sfs_flash_top
  import sfs_pkg::*;
#(
  parameter int PROG_TIME_US = sfs_pkg::SEC_PROG_TIME_US,
  // factory half content; value is arbitrary
  parameter logic [sfs_pkg::USER_BYTES-1:0][7:0] FACTORY_DATA = {64{8'hA5}}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi pins
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiSi,
  output logic spiSo,
  output logic spiSoOe,
  // write protect pin
  input wire logic wpN,
  // cell verify result, same clock domain, sampled at program end
  input wire logic cellFault
);
  import sfs_pkg::*;

  localparam int PROG_CYCLES = PROG_TIME_US * (CLK_FREQ_HZ / HZ_PER_MHZ);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    sfs_phase_e phase;
    logic [2:0] bitCnt;
    logic [7:0] inShift;
    logic [7:0] opcode;
    logic [1:0] byteCnt;
    logic [6:0] addr;
    logic [8:0] dataCount;
    logic [7:0] statusIn;
    logic [BUF_BYTES-1:0][7:0] buffer;
    logic [USER_BYTES-1:0][7:0] user;
    logic userProgrammed;
    logic [5:0] progAddr;
    logic [8:0] progCount;
    logic readyBusyFlag;
    logic [TW-1:0] timer;
    logic writeEnableLatch;
    logic arrayProtectFlag;
    logic protectLockFlag;
    logic programEraseErrorFlag;
    logic [7:0] outShift;
    logic [2:0] outCnt;
    logic outActive;
    logic so;
    logic soOe;
  } sfs_state_s;

  sfs_state_s s_q;
  sfs_state_s s_d;

  sfs_pins_if pins ();

  sfs_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .spiCsN(spiCsN),
    .spiClk(spiClk),
    .spiSi(spiSi),
    .wpN(wpN),
    .pins(pins.src)
  );

  // ==========================================================
  // read views
  logic [7:0] statusByte;
  logic [7:0] byteIn;
  logic [7:0] secByte;
  logic [7:0] nextSecByte;
  logic hwLocked;

  function automatic logic [7:0] sec_read(input logic [6:0] a,
                                          input logic [USER_BYTES-1:0][7:0] usr);
    // upper half is the fixed factory content
    sec_read = a[6] ? FACTORY_DATA[a[5:0]] : usr[a[5:0]];
  endfunction

  always_comb begin
    statusByte = 8'h00;
    statusByte[ST_READY_BUSY] = s_q.readyBusyFlag;
    statusByte[ST_WRITE_ENABLE] = s_q.writeEnableLatch;
    statusByte[ST_ARRAY_PROTECT] = s_q.arrayProtectFlag;
    // pin level is read live, so every repeated status byte is fresh
    statusByte[ST_PROTECT_PIN] = ~pins.wpAsserted;
    statusByte[ST_PROG_ERROR] = s_q.programEraseErrorFlag;
    statusByte[ST_PROTECT_LOCK] = s_q.protectLockFlag;
  end

  assign byteIn = {s_q.inShift[6:0], pins.si};
  assign secByte = sec_read(s_q.addr, s_q.user);
  assign nextSecByte = sec_read(s_q.addr, s_q.user);
  // hardware lock needs both the lock bit and the pin asserted
  assign hwLocked = s_q.protectLockFlag & pins.wpAsserted;

  // ==========================================================
  // program map: user byte g takes buffer entry (g - start) mod 64, so a
  // start near the top wraps inside the user half, never into factory data
  logic [USER_BYTES-1:0] progHit;
  logic [USER_BYTES-1:0][7:0] progData;

  for (genvar g = 0; g < USER_BYTES; g++) begin : g_prog
    logic [5:0] offset;
    assign offset = 6'(g) - s_q.progAddr;
    // entries past the received count stay erased
    assign progHit[g] = ({3'h0, offset} < s_q.progCount);
    assign progData[g] = s_q.buffer[offset];
  end

  // ==========================================================
  // release qualifiers: a part byte pending aborts every write-type command
  logic wholeBytes;
  logic progAccept;
  logic statusAccept;

  assign wholeBytes = (s_q.bitCnt == 3'h0);
  assign progAccept = (s_q.phase == PH_PROG_DATA) && wholeBytes
    && (s_q.dataCount != 9'h000) && s_q.writeEnableLatch
    && !s_q.userProgrammed;
  assign statusAccept = wholeBytes && (s_q.dataCount != 9'h000)
    && s_q.writeEnableLatch && !hwLocked;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;

    // ---- self-timed program of the user half
    if (s_q.readyBusyFlag) begin
      if (s_q.timer == '0) begin
        for (int i = 0; i < USER_BYTES; i++) begin
          if (progHit[i]) begin
            s_d.user[i] = progData[i];
          end
        end
        s_d.userProgrammed = 1'b1;
        s_d.readyBusyFlag = 1'b0;
        s_d.programEraseErrorFlag = cellFault;
      end else begin
        s_d.timer = s_q.timer - TW'(1);
      end
    end

    // ---- end of frame
    if (pins.csRise) begin
      // write enable/disable only move WRITE_ENABLE_LATCH once the whole opcode arrived with no part byte after it (bitCnt back at 0)
      if (s_q.opcode == OP_WRITE_ENABLE && s_q.bitCnt == 3'h0) begin
        s_d.writeEnableLatch = 1'b1;
      end
      if (s_q.opcode == OP_WRITE_DISABLE && s_q.bitCnt == 3'h0) begin
        s_d.writeEnableLatch = 1'b0;
      end
      if (s_q.opcode == OP_WRITE_STATUS) begin
        s_d.writeEnableLatch = 1'b0;
        if (statusAccept) begin
          s_d.arrayProtectFlag = s_q.statusIn[ST_ARRAY_PROTECT];
          // with the pin asserted the lock may only go from 0 to 1
          s_d.protectLockFlag = pins.wpAsserted
            ? (s_q.protectLockFlag | s_q.statusIn[ST_PROTECT_LOCK])
            : s_q.statusIn[ST_PROTECT_LOCK];
        end
      end
      if (s_q.opcode == OP_PROG_SECURITY) begin
        // completes or aborts: latch drops either way, before the end
        s_d.writeEnableLatch = 1'b0;
        if (progAccept) begin
          s_d.readyBusyFlag = 1'b1;
          // counted in system clocks, so the busy span tracks clk, not the link
          s_d.timer = TW'(PROG_CYCLES - 1);
          s_d.progAddr = s_q.addr[5:0];
          s_d.progCount = (s_q.dataCount > 9'(USER_BYTES))
            ? 9'(USER_BYTES) : s_q.dataCount;
        end
      end
    end

    // ---- framing
    if (!pins.csActive) begin
      s_d.phase = PH_OPCODE;
      s_d.bitCnt = 3'h0;
      s_d.opcode = OP_NONE;
      s_d.dataCount = 9'h000;
      s_d.outActive = 1'b0;
      s_d.soOe = 1'b0;
    end else begin
      if (pins.sckRise) begin
        s_d.inShift = byteIn;
        s_d.bitCnt = s_q.bitCnt + 3'h1;
        if (s_q.bitCnt == 3'h7) begin
          case (s_q.phase)
            PH_OPCODE: begin
              s_d.opcode = byteIn;
              s_d.byteCnt = 2'h0;
              s_d.phase = PH_TAIL;
              if (s_q.readyBusyFlag && byteIn != OP_READ_STATUS) begin
                // only status reads are served while busy
                s_d.opcode = OP_NONE;
              end else begin
                case (byteIn)
                  OP_READ_STATUS: begin
                    s_d.phase = PH_READ_STATUS;
                    s_d.outShift = statusByte;
                    s_d.outCnt = 3'h0;
                    s_d.outActive = 1'b1;
                  end
                  OP_READ_SECURITY: begin
                    s_d.phase = PH_ADDR;
                  end
                  OP_PROG_SECURITY: begin
                    s_d.phase = PH_ADDR;
                    s_d.buffer = {BUF_BYTES{ERASED_BYTE}};
                  end
                  OP_WRITE_STATUS: begin
                    s_d.phase = PH_STATUS_DATA;
                  end
                  default: begin
                    s_d.phase = PH_TAIL;
                  end
                endcase
              end
            end
            PH_ADDR: begin
              s_d.byteCnt = s_q.byteCnt + 2'h1;
              // upper address bits never reach the decoder
              s_d.addr = byteIn[6:0];
              if (s_q.byteCnt == 2'(ADDR_BYTES - 1)) begin
                s_d.byteCnt = 2'h0;
                s_d.phase = (s_q.opcode == OP_PROG_SECURITY) ? PH_PROG_DATA : PH_DUMMY;
              end
            end
            PH_DUMMY: begin
              s_d.byteCnt = s_q.byteCnt + 2'h1;
              if (s_q.byteCnt == 2'(DUMMY_BYTES - 1)) begin
                s_d.phase = PH_READ_SEC;
                s_d.outShift = secByte;
                s_d.addr = s_q.addr + 7'h01;
                s_d.outCnt = 3'h0;
                s_d.outActive = 1'b1;
              end
            end
            PH_PROG_DATA: begin
              // past 256 bytes every further byte lands in entry 0; only 64 entries ever program
              s_d.buffer[s_q.dataCount[7:0]] = byteIn;
              if (s_q.dataCount != 9'(BUF_BYTES)) begin
                s_d.dataCount = s_q.dataCount + 9'h001;
              end
            end
            PH_STATUS_DATA: begin
              // first data byte counts, anything after is dropped
              s_d.statusIn = byteIn;
              s_d.dataCount = 9'h001;
              s_d.phase = PH_TAIL;
            end
            default: begin
            end
          endcase
        end
      end

      // output moves a few clk after the pin fall: the link clock must stay
      // well below clk for the host to see it settled at its next rise
      if (pins.sckFall && s_q.outActive) begin
        s_d.so = s_q.outShift[7];
        s_d.soOe = 1'b1;
        s_d.outCnt = s_q.outCnt + 3'h1;
        if (s_q.outCnt == 3'h7) begin
          if (s_q.phase == PH_READ_STATUS) begin
            s_d.outShift = statusByte;
          end else begin
            s_d.outShift = nextSecByte;
            // seven-bit pointer rolls 7Fh to 00h with no gap
            s_d.addr = s_q.addr + 7'h01;
          end
        end else begin
          s_d.outShift = {s_q.outShift[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= PH_OPCODE;
      s_q.opcode <= OP_NONE;
      s_q.buffer <= {BUF_BYTES{ERASED_BYTE}};
      // one-time state is plain flip-flops, so a reset erases the user half
      s_q.user <= {USER_BYTES{ERASED_BYTE}};
      s_q.writeEnableLatch <= RST_WRITE_ENABLE;
      s_q.arrayProtectFlag <= RST_ARRAY_PROTECT;
      s_q.protectLockFlag <= RST_PROTECT_LOCK;
      s_q.programEraseErrorFlag <= RST_PROG_ERROR;
    end else begin
      s_q <= s_d;
    end
  end

  assign spiSo = s_q.so;
  assign spiSoOe = s_q.soOe;

endmodule // sfs_flash_top

`default_nettype wire

//--- verif/sfs_flash_asserts.sv
/*
  Pin-level checker for the security-register and status command block.
  Assumes mode 0 host traffic and the top module's ports only.
*/
`timescale 1ns/100ps
`default_nettype none

module sfs_flash_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi and side pins
  input wire logic spiCsN,
  input wire logic spiClk,
  input wire logic spiSi,
  input wire logic spiSo,
  input wire logic spiSoOe,
  input wire logic wpN,
  input wire logic cellFault
);
  logic [7:0] nRise_q;
  logic [7:0] nRise_d;
  logic sckPrev_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // raw serial clock rises in this frame, saturating
  always_comb begin
    nRise_d = nRise_q;
    if (spiClk && !sckPrev_q && nRise_q != 8'hFF) nRise_d = nRise_q + 8'h01;
    if (spiCsN) nRise_d = 8'h00;
  end
  always_ff @(posedge clk) begin
    sckPrev_q <= spiClk;
    nRise_q <= rst ? 8'h00 : nRise_d;
  end

  // ==========================================================
  // properties
  sequence s_cs_up;
    $rose(spiCsN) ##1 spiCsN [*6];
  endsequence
  sequence s_oe_off;
    $fell(spiSoOe);
  endsequence
  property p_oe_release;
    $rose(spiCsN) |-> ##[1:6] !spiSoOe;
  endproperty
  property p_oe_idle;
    s_cs_up |-> !spiSoOe;
  endproperty
  property p_so_on_fall;
    $changed(spiSo) |-> !$past(spiClk, 2);
  endproperty
  property p_oe_rise_fall;
    $rose(spiSoOe) |-> !$past(spiClk, 2) && !$past(spiCsN, 2);
  endproperty
  property p_oe_fall_cs;
    $fell(spiSoOe) |-> $past(spiCsN, 2);
  endproperty
  property p_oe_after_op;
    $rose(spiSoOe) |-> nRise_q >= 8'h08;
  endproperty
  property p_oe_quiet;
    s_oe_off |-> !spiSoOe [*8];
  endproperty
  property p_oe_needs_cs;
    spiSoOe |-> !$past(spiCsN, 6);
  endproperty

  a_oe_release: assert property (p_oe_release)
    else $error("output enable held after deselect");
  a_oe_idle: assert property (p_oe_idle)
    else $error("output enabled while deselected");
  a_so_on_fall: assert property (p_so_on_fall)
    else $error("serial output moved outside the low clock phase");
  a_oe_rise_fall: assert property (p_oe_rise_fall)
    else $error("output enable rose without a falling clock");
  a_oe_fall_cs: assert property (p_oe_fall_cs)
    else $error("output enable dropped while selected");
  a_oe_after_op: assert property (p_oe_after_op)
    else $error("output started before a whole opcode");
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("output enable came straight back");
  a_oe_needs_cs: assert property (p_oe_needs_cs)
    else $error("output enabled long after deselect");
endmodule // sfs_flash_asserts

`default_nettype wire

//--- verif/sfs_spi_host.sv
/*
  Behavioural SPI host, mode 0, 8 clk per serial bit (160 ns).
  Assumes the bench fills txBuf before each frame and reads rxBuf after.
*/
`timescale 1ns/100ps
`default_nettype none

module sfs_spi_host (
  // clock
  input wire logic clk,
  // spi pins
  output logic spiCsN,
  output logic spiClk,
  output logic spiSi,
  input wire logic spiSo,
  input wire logic spiSoOe
);
  logic [7:0] txBuf [0:15];
  logic [7:0] rxBuf [0:15];

  initial begin
    spiCsN = 1'b1;
    spiClk = 1'b0;
    spiSi = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // clock stands still low between frames
  task automatic xfer(input int nBytes, input int extra);
    int i;
    @(posedge clk);
    spiCsN <= 1'b0;
    waitClk(4);
    for (i = 0; i < nBytes * 8 + extra; i++) begin
      spiSi <= txBuf[i / 8][7 - i % 8];
      waitClk(4);
      spiClk <= 1'b1;
      waitClk(2);
      rxBuf[i / 8][7 - i % 8] = spiSoOe ? spiSo : 1'bx;
      waitClk(2);
      spiClk <= 1'b0;
    end
    waitClk(4);
    spiCsN <= 1'b1;
    spiSi <= ~spiSi;
    waitClk(6);
  endtask
endmodule // sfs_spi_host

`default_nettype wire

//--- verif/sfs_flash_top_tb.sv
/*
  Self-checking bench: SPI frame sequences with expected status and data.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module sfs_flash_top_tb;
  import sfs_pkg::*;
  logic clk;
  logic rst;
  logic wpN;
  logic cellFault;
  wire logic spiCsN;
  wire logic spiClk;
  wire logic spiSi;
  wire logic spiSo;
  wire logic spiSoOe;
  int nFail;
  int numChecks;
  int i;
  logic [7:0] expRd [0:7] = '{8'h5A, 8'h5A, 8'hFF, 8'hFF, 8'h11, 8'h22, 8'h33, 8'hFF};

  // short program time keeps busy at 200 clk
  sfs_flash_top #(.PROG_TIME_US(4), .FACTORY_DATA({64{8'h5A}})) DUT (
    .clk(clk), .rst(rst), .spiCsN(spiCsN), .spiClk(spiClk), .spiSi(spiSi),
    .spiSo(spiSo), .spiSoOe(spiSoOe), .wpN(wpN), .cellFault(cellFault));
  sfs_spi_host host (
    .clk(clk), .spiCsN(spiCsN), .spiClk(spiClk), .spiSi(spiSi),
    .spiSo(spiSo), .spiSoOe(spiSoOe));

  // ==========================================================
  // helpers
  task automatic close_out();
    if (nFail == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      nFail++;
    end
  endtask
  task automatic frame(input logic [31:0] head, input int n, input int extra);
    int k;
    for (k = 0; k < 4; k++) host.txBuf[k] = head[31 - 8 * k -: 8];
    host.xfer(n, extra);
  endtask
  task automatic statusIs(input logic [7:0] exp, input logic [7:0] mask);
    frame({OP_READ_STATUS, 24'h0}, 2, 0);
    check8("status", exp, host.rxBuf[1] & mask);
  endtask
  task automatic wren();
    frame({OP_WRITE_ENABLE, 24'h0}, 1, 0);
  endtask
  task automatic wrsr(input logic [7:0] v);
    wren();
    frame({OP_WRITE_STATUS, v, 16'h0}, 2, 0);
  endtask

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    wpN = 1'b1;
    cellFault = 1'b0;
    nFail = 0;
    numChecks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    statusIs(8'h10, 8'hFF);
    frame({OP_READ_STATUS, 24'h0}, 3, 0);
    check8("status repeat", 8'h10, host.rxBuf[2]);
    wpN <= 1'b0;
    statusIs(8'h00, 8'hFF);
    wpN <= 1'b1;
    frame({OP_WRITE_ENABLE, 24'h0}, 1, 3);
    statusIs(8'h10, 8'hFF);
    wren();
    statusIs(8'h12, 8'hFF);
    frame({OP_PROG_SECURITY, 24'h0}, 3, 0);
    statusIs(8'h10, 8'hFF);
    frame({OP_PROG_SECURITY, 24'h0}, 5, 0);
    statusIs(8'h10, 8'hFF);
    wrsr(8'hFF);
    statusIs(8'h94, 8'hFF);
    wpN <= 1'b0;
    wrsr(8'h00);
    statusIs(8'h84, 8'hFF);
    wpN <= 1'b1;
    wrsr(8'h00);
    statusIs(8'h10, 8'hFF);
    cellFault <= 1'b1;
    wren();
    host.txBuf[4] = 8'h11;
    host.txBuf[5] = 8'h22;
    host.txBuf[6] = 8'h33;
    frame({OP_PROG_SECURITY, 24'hFFFFC2}, 7, 0);
    statusIs(8'h01, 8'h03);
    for (i = 0; i < 10 && host.rxBuf[1][0] !== 1'b0; i++) begin
      frame({OP_READ_STATUS, 24'h0}, 2, 0);
    end
    statusIs(8'h30, 8'hFF);
    frame({OP_READ_SECURITY, 24'h00007E}, 14, 0);
    for (i = 0; i < 8; i++) check8("security", expRd[i], host.rxBuf[6 + i]);
    wren();
    frame({OP_PROG_SECURITY, 24'h0}, 5, 0);
    statusIs(8'h30, 8'hFF);
    // an accepted reprogram would have put 11h into location 0
    frame({OP_READ_SECURITY, 24'h000000}, 7, 0);
    check8("security", 8'hFF, host.rxBuf[6]);
    frame({OP_READ_STATUS, 24'h0}, 1, 3);
    check8("status part", 8'h20, host.rxBuf[1] & 8'hE0);
    // second reset: fresh part, program that passes its cell check
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cellFault <= 1'b0;
    repeat (4) @(posedge clk);
    statusIs(8'h10, 8'hFF);
    wren();
    frame({OP_PROG_SECURITY, 24'h00003F}, 4, 4);
    statusIs(8'h10, 8'hFF);
    wren();
    frame({OP_PROG_SECURITY, 24'h00003F}, 5, 0);
    repeat (300) @(posedge clk);
    statusIs(8'h10, 8'hFF);
    frame({OP_READ_SECURITY, 24'h00003E}, 9, 0);
    check8("security lo", 8'hFF, host.rxBuf[6]);
    check8("security last", 8'h11, host.rxBuf[7]);
    check8("security factory", 8'h5A, host.rxBuf[8]);
    close_out();
  end
endmodule // sfs_flash_top_tb

bind sfs_flash_top sfs_flash_asserts u_chk (
  .clk(clk), .rst(rst), .spiCsN(spiCsN), .spiClk(spiClk), .spiSi(spiSi),
  .spiSo(spiSo), .spiSoOe(spiSoOe), .wpN(wpN), .cellFault(cellFault));

`default_nettype wire
